// >>> hdl/cvps_consts.svh
// constants for the config variable programming sequencer
`ifndef CVPS_CONSTS_SVH
`define CVPS_CONSTS_SVH
`define CVPS_CLK_MHZ 125
`define CVPS_STEADY_MS 1000
`define CVPS_SLOW_MS 500
`define CVPS_SHORT_MS 100
`define CVPS_FAST_MS 50
`define CVPS_PAIR_ZERO 8'h50
`define CVPS_SHORT_LIMIT 8'h50
`define CVPS_LONG_KEY 8'h07
`define CVPS_TEN 8'h0a
`endif

// >>> hdl/cvps_lamp.sv
// headlight flasher that plays the signalling patterns
`timescale 1ns/1ps
`include "cvps_consts.svh"
module cvps_lamp
  import cvps_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = `CVPS_CLK_MHZ * 1000 * `CVPS_FAST_MS
)(
  input wire logic clk_in,
  input wire logic reset_in,
  cvps_lamp_if.lamp req,
  output logic lamp_out
);
  logic [31:0] tick_q, tick_d;
  logic [3:0] slot_q, slot_d;
  logic lamp_q, lamp_d;
  logic [15:0] pat_bits;

  // sixteen slot bit pattern per request; one slot is one unit
  // a long pulse is three lit slots, a short one lit slot, a dark slot between pulses
  always_comb
  begin
    unique case (req.pattern)
      CVPS_PAT_OFF: pat_bits = 16'h0000;
      CVPS_PAT_BRIEF: pat_bits = 16'h0101;
      CVPS_PAT_TWICE: pat_bits = 16'h0005;
      CVPS_PAT_SLOW: pat_bits = 16'h00ff;
      CVPS_PAT_LS: pat_bits = 16'h1717;
      CVPS_PAT_LSS: pat_bits = 16'h5757;
      CVPS_PAT_LSSS: pat_bits = 16'h0157;
      CVPS_PAT_ON: pat_bits = 16'hffff;
    endcase
  end

  // slot sequencer; the twice pattern plays only once
  always_comb
  begin
    tick_d = tick_q + 32'h1;
    slot_d = slot_q;
    if (req.restart)
    begin
      tick_d = 32'h0;
      slot_d = 4'h0;
    end
    else if (tick_q >= UNIT_CYCLES - 1)
    begin
      tick_d = 32'h0;
      if (!(req.pattern == CVPS_PAT_TWICE && slot_q == 4'hf))
        slot_d = slot_q + 4'h1;
    end
    lamp_d = pat_bits[slot_d];
  end

  // registers
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      tick_q <= 32'h0;
      slot_q <= 4'h0;
      lamp_q <= 1'b0;
    end
    else
    begin
      tick_q <= tick_d;
      slot_q <= slot_d;
      lamp_q <= lamp_d;
    end
  end

  assign lamp_out = lamp_q;
endmodule : cvps_lamp

// >>> hdl/cvps_lamp_if.sv
// pattern request channel between sequencer and lamp flasher
`timescale 1ns/1ps
interface cvps_lamp_if;
  import cvps_pkg::*;
  cvps_pat_t pattern;
  logic restart;
  modport seq (output pattern, output restart);
  modport lamp (input pattern, input restart);
endinterface : cvps_lamp_if

// >>> hdl/cvps_pkg.sv
// types for the config variable programming sequencer
package cvps_pkg;
  typedef enum logic [3:0] {
    CVPS_IDLE, CVPS_S_NUM, CVPS_S_VAL, CVPS_L_NUM_HI, CVPS_L_NUM_LO,
    CVPS_L_VAL_HI, CVPS_L_VAL_LO, CVPS_STEADY
  } cvps_state_t;
  typedef enum logic [2:0] {
    CVPS_PAT_OFF, CVPS_PAT_BRIEF, CVPS_PAT_TWICE, CVPS_PAT_SLOW, CVPS_PAT_LS, CVPS_PAT_LSS,
    CVPS_PAT_LSSS, CVPS_PAT_ON
  } cvps_pat_t;
endpackage : cvps_pkg

// >>> hdl/cvps_seq.sv
// config variable programming sequencer of a locomotive decoder
// Function
// - accept direct, register, paged track writes and addressed main-track writes.
// - main-track writes are applied, never answered with read data.
// - unaddressed programming-track writes execute regardless of our address.
// - bits inside a config variable are numbered 0 (lsb) to 7 (msb).
// - two-digit entry procedure only writes, never returns stored values.
// - short mode accepts number below 80 with value below 80.
// - long mode writes any variable with any value 0 to 255.
// - entered pair 80 means value zero.
// - entering short mode flashes briefly, then waits for a number.
// - confirmed number flashes twice quickly, then waits for value.
// - confirmed value is stored, lamps steady one second, then next entry.
// - number entry 80 in short mode or power cycle ends programming.
// - 07 into variable 07 switches to long mode, signalled by slow flash.
// - long number hi, flash long-short, units, flash long-short-short.
// - long value hi, flash long-short-short-short, units, then final confirm.
// - long mode lasts across writes until a power cycle.
`timescale 1ns/1ps
`include "cvps_consts.svh"
module cvps_seq
  import cvps_pkg::*;
#(
  parameter int unsigned STEADY_CYCLES = `CVPS_CLK_MHZ * 1000 * `CVPS_STEADY_MS,
  parameter int unsigned UNIT_CYCLES = `CVPS_CLK_MHZ * 1000 * `CVPS_FAST_MS
)(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic power_up_in,
  input wire logic addr_match_in,
  input wire logic dir_held_in,
  input wire logic entry_valid_in,
  input wire logic [7:0] entry_in,
  input wire logic dir_change_in,
  input wire logic dcc_write_in,
  input wire logic dcc_main_in,
  input wire logic dcc_addressed_in,
  input wire logic [9:0] dcc_cv_in,
  input wire logic [7:0] dcc_data_in,
  output logic wr_en_out,
  output logic [9:0] wr_cv_out,
  output logic [7:0] wr_data_out,
  output logic prog_active_out,
  output logic long_mode_out,
  output logic lamp_out
);
  cvps_state_t state_q, state_d, ret_q, ret_d;
  logic long_q, long_d;
  logic [7:0] entry_q, entry_d;
  logic [7:0] num_hi_q, num_hi_d;
  logic [9:0] cv_q, cv_d;
  logic [7:0] val_hi_q, val_hi_d;
  logic [31:0] hold_q, hold_d;
  logic wr_q, wr_d;
  logic [9:0] wcv_q, wcv_d;
  logic [7:0] wdat_q, wdat_d;
  cvps_pat_t pat_q, pat_d;
  logic restart;
  logic [7:0] entry_val;
  logic [9:0] comb_num;
  logic [9:0] comb_val;

  cvps_lamp_if lamp_ch ();

  // entered pair 80 stands for zero
  assign entry_val = (entry_q == `CVPS_PAIR_ZERO) ? 8'h00 : entry_q;
  // hi times ten plus units for long mode
  assign comb_num = 10'(num_hi_q) * 10'(`CVPS_TEN) + 10'(entry_val);
  assign comb_val = 10'(val_hi_q) * 10'(`CVPS_TEN) + 10'(entry_val);

  // entry sequencer next state
  always_comb
  begin
    state_d = state_q;
    ret_d = ret_q;
    long_d = long_q;
    entry_d = entry_valid_in ? entry_in : entry_q;
    num_hi_d = num_hi_q;
    cv_d = cv_q;
    val_hi_d = val_hi_q;
    hold_d = hold_q;
    pat_d = pat_q;
    wr_d = 1'b0;
    wcv_d = wcv_q;
    wdat_d = wdat_q;
    if (power_up_in)
    begin
      // power restored: a held direction with our address enters, else leave
      long_d = 1'b0;
      pat_d = CVPS_PAT_OFF;
      state_d = CVPS_IDLE;
      if (dir_held_in && addr_match_in)
      begin
        state_d = CVPS_S_NUM;
        pat_d = CVPS_PAT_BRIEF;
      end
    end
    else if (state_q == CVPS_IDLE)
    begin
      // ordinary dcc programming: writes only, no answers produced
      if (dcc_write_in && (dcc_main_in ? dcc_addressed_in : 1'b1))
      begin
        wr_d = 1'b1;
        wcv_d = dcc_cv_in;
        wdat_d = dcc_data_in;
      end
    end
    else if (state_q == CVPS_STEADY)
    begin
      if (hold_q >= STEADY_CYCLES - 1)
      begin
        state_d = ret_q;
        pat_d = (ret_q == CVPS_L_NUM_HI) ? CVPS_PAT_SLOW : CVPS_PAT_BRIEF;
      end
      else
        hold_d = hold_q + 32'h1;
    end
    else if (dir_change_in)
    begin
      unique case (state_q)
        CVPS_S_NUM:
        begin
          if (entry_q == `CVPS_PAIR_ZERO)
          begin
            state_d = CVPS_IDLE;
            pat_d = CVPS_PAT_OFF;
          end
          else if (entry_q < `CVPS_SHORT_LIMIT)
          begin
            cv_d = 10'(entry_q);
            state_d = CVPS_S_VAL;
            pat_d = CVPS_PAT_TWICE;
          end
        end
        CVPS_S_VAL:
        begin
          if (entry_q == `CVPS_LONG_KEY && cv_q == 10'(`CVPS_LONG_KEY))
          begin
            long_d = 1'b1;
            state_d = CVPS_L_NUM_HI;
            pat_d = CVPS_PAT_SLOW;
          end
          else if (entry_val < `CVPS_SHORT_LIMIT)
          begin
            wr_d = 1'b1;
            wcv_d = cv_q;
            wdat_d = entry_val;
            state_d = CVPS_STEADY;
            ret_d = CVPS_S_NUM;
            hold_d = 32'h0;
            pat_d = CVPS_PAT_ON;
          end
        end
        CVPS_L_NUM_HI:
        begin
          num_hi_d = entry_val;
          state_d = CVPS_L_NUM_LO;
          pat_d = CVPS_PAT_LS;
        end
        CVPS_L_NUM_LO:
        begin
          cv_d = comb_num;
          state_d = CVPS_L_VAL_HI;
          pat_d = CVPS_PAT_LSS;
        end
        CVPS_L_VAL_HI:
        begin
          val_hi_d = entry_val;
          state_d = CVPS_L_VAL_LO;
          pat_d = CVPS_PAT_LSSS;
        end
        CVPS_L_VAL_LO:
        begin
          if (comb_val <= 10'h0ff)
          begin
            wr_d = 1'b1;
            wcv_d = cv_q;
            wdat_d = comb_val[7:0];
          end
          state_d = CVPS_STEADY;
          ret_d = CVPS_L_NUM_HI;
          hold_d = 32'h0;
          pat_d = CVPS_PAT_ON;
        end
        default:
        begin
          state_d = CVPS_IDLE;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state_q <= CVPS_IDLE;
      ret_q <= CVPS_S_NUM;
      long_q <= 1'b0;
      entry_q <= 8'h00;
      num_hi_q <= 8'h00;
      cv_q <= 10'h000;
      val_hi_q <= 8'h00;
      hold_q <= 32'h0;
      pat_q <= CVPS_PAT_OFF;
      wr_q <= 1'b0;
      wcv_q <= 10'h000;
      wdat_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      ret_q <= ret_d;
      long_q <= long_d;
      entry_q <= entry_d;
      num_hi_q <= num_hi_d;
      cv_q <= cv_d;
      val_hi_q <= val_hi_d;
      hold_q <= hold_d;
      pat_q <= pat_d;
      wr_q <= wr_d;
      wcv_q <= wcv_d;
      wdat_q <= wdat_d;
    end
  end

  // restart the flasher whenever the pattern changes
  assign restart = (pat_d != pat_q);
  assign lamp_ch.pattern = pat_q;
  assign lamp_ch.restart = restart;

  cvps_lamp #(.UNIT_CYCLES(UNIT_CYCLES)) u_lamp (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .req(lamp_ch.lamp),
    .lamp_out(lamp_out)
  );

  assign wr_en_out = wr_q;
  assign wr_cv_out = wcv_q;
  assign wr_data_out = wdat_q;
  assign prog_active_out = (state_q != CVPS_IDLE);
  assign long_mode_out = long_q;

  // checks
  a_short_limit: assert property (@(posedge clk_in) disable iff (reset_in)
    (wr_q && !long_q && state_q == CVPS_STEADY && ret_q == CVPS_S_NUM) |-> wdat_q < `CVPS_SHORT_LIMIT)
    else $error("short write value out of range");
  a_exit_eighty: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == CVPS_S_NUM && dir_change_in && !power_up_in && entry_q == `CVPS_PAIR_ZERO)
    |=> state_q == CVPS_IDLE)
    else $error("entry 80 did not end programming");
  a_long_enter: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == CVPS_S_VAL && dir_change_in && !power_up_in && entry_q == `CVPS_LONG_KEY && cv_q == 10'h007)
    |=> long_q && pat_q == CVPS_PAT_SLOW)
    else $error("long mode not entered");
  a_long_keep: assert property (@(posedge clk_in) disable iff (reset_in)
    (long_q && !power_up_in) |=> long_q)
    else $error("long mode lost without power cycle");
  a_twice_after: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(state_q == CVPS_S_VAL) |-> pat_q == CVPS_PAT_TWICE)
    else $error("number confirm not flashed twice");
  a_zero_map: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == CVPS_S_VAL && dir_change_in && !power_up_in && entry_q == `CVPS_PAIR_ZERO && cv_q != 10'h007)
    |=> wr_q && wdat_q == 8'h00)
    else $error("entry 80 not written as zero");
  a_steady_on: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == CVPS_STEADY) |-> pat_q == CVPS_PAT_ON)
    else $error("lamps not steady after store");
  a_enter_brief: assert property (@(posedge clk_in) disable iff (reset_in)
    (power_up_in && dir_held_in && addr_match_in) |=> state_q == CVPS_S_NUM && pat_q == CVPS_PAT_BRIEF)
    else $error("programming entry not signalled");
  a_main_addr: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == CVPS_IDLE && !power_up_in && dcc_write_in && dcc_main_in && !dcc_addressed_in) |=> !wr_q)
    else $error("unaddressed main write applied");
endmodule : cvps_seq

// >>> test/cvps_seq_tb.sv
// self-checking bench for the programming sequencer
`timescale 1ns/1ps
module cvps_seq_tb;
  typedef struct {
    logic [7:0] cv;
    logic [7:0] ent;
    logic [7:0] dat;
  } cvps_row_t;
  typedef struct {
    logic [7:0] nhi;
    logic [7:0] nlo;
    logic [7:0] vhi;
    logic [7:0] vlo;
    logic [9:0] cv;
    logic [7:0] dat;
  } cvps_lrow_t;
  typedef struct {
    logic main;
    logic addr;
    logic [9:0] cv;
    logic [7:0] dat;
    logic wr;
  } cvps_drow_t;
  localparam int UNIT = 4;
  localparam int STEADY = 200;
  logic clk_in, reset_in, power_up, addr_match, dir_held, entry_valid, dir_change;
  logic dcc_write, dcc_main, dcc_addressed, wr_en, prog_active, long_mode, lamp;
  logic [7:0] entry, dcc_data, wr_data;
  logic [9:0] dcc_cv, wr_cv;
  int num_errors = 0;
  int n_checks = 0;
  cvps_row_t rows [3] = '{'{8'h01, 8'h0f, 8'h0f}, '{8'h4f, 8'h4f, 8'h4f}, '{8'h03, 8'h50, 8'h00}};
  // long rows: number hi, units, value hi, units, then the stored target and data
  cvps_lrow_t lrows [2] = '{'{8'h0c, 8'h04, 8'h0d, 8'h05, 10'h07c, 8'h87},
    '{8'h00, 8'h09, 8'h19, 8'h00, 10'h009, 8'hfa}};
  // track writes: main, addressed, target, data, write expected
  cvps_drow_t drows [3] = '{'{1'b0, 1'b0, 10'h003, 8'h80, 1'b1}, '{1'b1, 1'b1, 10'h3ff, 8'h01, 1'b1},
    '{1'b1, 1'b0, 10'h011, 8'h22, 1'b0}};
  int nl, ns;

  cvps_seq #(.STEADY_CYCLES(STEADY), .UNIT_CYCLES(UNIT)) dut_u (.clk_in(clk_in), .reset_in(reset_in),
    .power_up_in(power_up), .addr_match_in(addr_match), .dir_held_in(dir_held),
    .entry_valid_in(entry_valid), .entry_in(entry), .dir_change_in(dir_change),
    .dcc_write_in(dcc_write), .dcc_main_in(dcc_main), .dcc_addressed_in(dcc_addressed),
    .dcc_cv_in(dcc_cv), .dcc_data_in(dcc_data), .wr_en_out(wr_en), .wr_cv_out(wr_cv),
    .wr_data_out(wr_data), .prog_active_out(prog_active), .long_mode_out(long_mode), .lamp_out(lamp));
  cvps_station st_u (.clk_in(clk_in), .power_up_out(power_up), .addr_match_out(addr_match),
    .dir_held_out(dir_held), .entry_valid_out(entry_valid), .entry_out(entry), .dir_change_out(dir_change));

  // 125 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_vec(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_vec

  // bounded wait for the store pulse, then compare target and data
  task automatic expect_wr(input logic [9:0] cv, input logic [7:0] d);
    int k;
    k = 0;
    while (wr_en !== 1'b1 && k < 20)
    begin
      @(negedge clk_in);
      k++;
    end
    chk_bit("wr_en", 1'b1, wr_en);
    chk_vec("wr_cv", cv, wr_cv);
    chk_vec("wr_data", {2'h0, d}, {2'h0, wr_data});
  endtask : expect_wr

  // lamps steady after a store, then wait out the steady span
  task automatic steady_gap;
    repeat (8) @(negedge clk_in);
    chk_bit("lamp steady", 1'b1, lamp);
    repeat (STEADY) @(negedge clk_in);
  endtask : steady_gap

  // long and short lamp pulses over one pattern period right after a pattern change
  task automatic runs(output int n_long, output int n_short);
    int len;
    n_long = 0;
    n_short = 0;
    len = 0;
    repeat (16 * UNIT + 1)
    begin
      @(negedge clk_in);
      if (lamp === 1'b1)
        len++;
      else
      begin
        if (len > UNIT + UNIT / 2)
          n_long++;
        else if (len > 0)
          n_short++;
        len = 0;
      end
    end
  endtask : runs

  task automatic dcc(input logic m, input logic a, input logic [9:0] cv, input logic [7:0] d);
    @(negedge clk_in);
    dcc_main = m;
    dcc_addressed = a;
    dcc_cv = cv;
    dcc_data = d;
    dcc_write = 1'b1;
    @(negedge clk_in);
    dcc_write = 1'b0;
  endtask : dcc

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  // watchdog well beyond the expected few thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    conclude();
  end

  // main sequence
  initial
  begin
    int s;
    reset_in = 1'b1;
    {dcc_write, dcc_main, dcc_addressed, dcc_cv, dcc_data} = '0;
    repeat (16) @(negedge clk_in);
    reset_in = 1'b0;
    st_u.power(1'b1, 1'b0);
    chk_bit("foreign address", 1'b0, prog_active);
    st_u.power(1'b1, 1'b1);
    chk_bit("prog_active", 1'b1, prog_active);
    runs(nl, ns);
    chk_bit("short flash", 1'b1, nl == 0 && ns > 0);
    foreach (rows[i])
    begin
      st_u.put(rows[i].cv);
      runs(nl, ns);
      chk_bit("number flash", 1'b1, nl == 0 && ns == 2);
      st_u.put(rows[i].ent);
      expect_wr({2'h0, rows[i].cv}, rows[i].dat);
      steady_gap();
    end
    $display("short rows done");
    st_u.put(8'h50);
    repeat (4) @(negedge clk_in);
    chk_bit("exit by 80", 1'b0, prog_active);
    $display("short exit done");
    st_u.power(1'b1, 1'b1);
    st_u.put(8'h07);
    st_u.put(8'h07);
    runs(nl, ns);
    chk_bit("slow flash", 1'b1, nl > 0 && ns == 0);
    chk_bit("long_mode", 1'b1, long_mode);
    foreach (lrows[i])
    begin
      st_u.put(lrows[i].nhi);
      runs(nl, ns);
      chk_bit("long short", 1'b1, nl > 0 && ns == nl);
      st_u.put(lrows[i].nlo);
      runs(nl, ns);
      chk_bit("long short short", 1'b1, nl > 0 && ns == 2 * nl);
      st_u.put(lrows[i].vhi);
      runs(nl, ns);
      chk_bit("long short x3", 1'b1, nl > 0 && ns == 3 * nl);
      st_u.put(lrows[i].vlo);
      expect_wr(lrows[i].cv, lrows[i].dat);
      chk_bit("long kept", 1'b1, long_mode);
      steady_gap();
    end
    st_u.power(1'b0, 1'b1);
    repeat (2) @(negedge clk_in);
    chk_bit("power cycle", 1'b0, prog_active);
    chk_bit("long ends", 1'b0, long_mode);
    $display("long mode done");
    foreach (drows[i])
    begin
      dcc(drows[i].main, drows[i].addr, drows[i].cv, drows[i].dat);
      if (drows[i].wr)
        expect_wr(drows[i].cv, drows[i].dat);
      else
      begin
        s = 0;
        repeat (6)
        begin
          @(negedge clk_in);
          if (wr_en !== 1'b0)
            s++;
        end
        chk_bit("foreign main write", 1'b1, s == 0);
      end
    end
    $display("track writes done");
    st_u.power(1'b1, 1'b1);
    @(negedge clk_in);
    reset_in = 1'b1;
    repeat (2) @(negedge clk_in);
    reset_in = 1'b0;
    @(negedge clk_in);
    chk_bit("reset prog", 1'b0, prog_active);
    chk_bit("reset lamp", 1'b0, lamp);
    $display("reset done");
    conclude();
  end
endmodule : cvps_seq_tb

// >>> test/cvps_station.sv
// command station model driving power, address and two-digit entries
`timescale 1ns/1ps
module cvps_station (
  input wire logic clk_in,
  output logic power_up_out,
  output logic addr_match_out,
  output logic dir_held_out,
  output logic entry_valid_out,
  output logic [7:0] entry_out,
  output logic dir_change_out
);
  // idle levels at time zero
  initial
  begin
    power_up_out = 1'b0;
    addr_match_out = 1'b0;
    dir_held_out = 1'b0;
    entry_valid_out = 1'b0;
    entry_out = 8'h00;
    dir_change_out = 1'b0;
  end

  // power returns, with direction held and our address chosen as asked
  task automatic power(input logic held, input logic ours);
    @(negedge clk_in);
    addr_match_out = ours;
    dir_held_out = held;
    power_up_out = 1'b1;
    @(negedge clk_in);
    power_up_out = 1'b0;
    dir_held_out = 1'b0;
    addr_match_out = 1'b0;
  endtask : power

  // one entry of 1..80, zero sent as 80, then a direction change
  task automatic put(input logic [7:0] pair);
    @(negedge clk_in);
    entry_out = (pair == 8'h00) ? 8'h50 : pair;
    entry_valid_out = 1'b1;
    @(negedge clk_in);
    entry_valid_out = 1'b0;
    entry_out = ~entry_out; // stale value no longer qualified
    repeat (2) @(negedge clk_in);
    dir_change_out = 1'b1;
    @(negedge clk_in);
    dir_change_out = 1'b0;
  endtask : put
endmodule : cvps_station
